// [rtl/ftl_pkg.sv]
package ftl_pkg;
  // program memory calibration region
  localparam logic [13:0] FTL_CAL_BASE = 14'h2080;
  localparam logic [13:0] FTL_CAL_LAST = 14'h208F;
  localparam logic [13:0] FTL_AMP_OFFSET_CAL_WORD = 14'h2080;
  localparam logic [13:0] FTL_DESAT_AND_RESISTOR_CAL_WORD = 14'h2081;
  localparam logic [13:0] FTL_REFERENCE_CAL_WORD = 14'h2082;
  localparam logic [13:0] FTL_THERMAL_THRESHOLD_CAL_WORD = 14'h2083;
  // factory programmed value of an unprogrammed cell is all ones
  localparam logic [13:0] FTL_CAL_ERASED = 14'h3FFF;
  // implemented bits of each calibration word
  localparam logic [13:0] FTL_WORD1_MASK = 14'h007F;
  localparam logic [13:0] FTL_WORD2_MASK = 14'h1F3F;
  localparam logic [13:0] FTL_WORD3_MASK = 14'h001F;
  localparam logic [13:0] FTL_WORD4_MASK = 14'h000F;
  // field positions
  localparam int FTL_AMP_LSB = 0;
  localparam int FTL_AMP_W = 7;
  localparam int FTL_DESAT_LSB = 8;
  localparam int FTL_DESAT_W = 5;
  localparam int FTL_RES_LSB = 0;
  localparam int FTL_RES_W = 6;
  localparam int FTL_REF_LSB = 0;
  localparam int FTL_REF_W = 5;
  localparam int FTL_THERM_LSB = 0;
  localparam int FTL_THERM_W = 4;
  // alternate no-offset codes of the amplifier and desat trims
  localparam logic [6:0] FTL_AMP_MID_ALT = 7'h20;
  localparam logic [4:0] FTL_DESAT_MID_ALT = 5'h10;
  // bank 3 trim register addresses
  localparam logic [8:0] FTL_DESAT_TRIM_REG = 9'h196;
  localparam logic [8:0] FTL_RESISTOR_TRIM_REG = 9'h197;
  localparam logic [8:0] FTL_AMP_OFFSET_TRIM_REG = 9'h199;
  localparam logic [8:0] FTL_THERMAL_THRESHOLD_TRIM_REG = 9'h19A;
  localparam logic [8:0] FTL_REFERENCE_TRIM_REG = 9'h19B;
  // trim register reset values
  localparam logic [7:0] FTL_TRIM_RESET = 8'h00;
endpackage

// [rtl/ftl_trim_decode.sv]
`timescale 1ns/1ps
`default_nettype none
// turns a sign-magnitude trim code into a two's complement offset
module ftl_trim_decode #(
  parameter int W = 5,
  parameter logic [W-1:0] MID_ALT = '0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // code in, offset out
  input wire logic [W-1:0] code_i,
  output logic [W-1:0] offset_o,
  output logic zero_o
);
  logic [W-2:0] mag;
  logic is_zero;
  logic [W-1:0] offset_nxt;

  assign mag = code_i[W-2:0];
  // msb carries polarity only; a zero magnitude (either msb) and the MID_ALT code mean no offset
  assign is_zero = (mag == '0) || (code_i == MID_ALT);
  assign offset_nxt = is_zero ? '0 : (code_i[W-1] ? (~{1'b0, mag} + 1'b1) : {1'b0, mag});

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      offset_o <= '0;
      zero_o <= 1'b1;
    end else begin
      offset_o <= offset_nxt;
      zero_o <= is_zero;
    end
  end
endmodule // ftl_trim_decode
`default_nettype wire

// [rtl/ftl_loader.sv]
`timescale 1ns/1ps
`default_nettype none
module ftl_loader
  import ftl_pkg::*;
#(
  // factory contents; all-ones models an unprogrammed part
  parameter logic [13:0] CAL_WORD1 = ftl_pkg::FTL_CAL_ERASED,
  parameter logic [13:0] CAL_WORD2 = ftl_pkg::FTL_CAL_ERASED,
  parameter logic [13:0] CAL_WORD3 = ftl_pkg::FTL_CAL_ERASED,
  parameter logic [13:0] CAL_WORD4 = ftl_pkg::FTL_CAL_ERASED
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // program memory port
  input wire logic pm_rd_i,
  input wire logic pm_wr_i,
  input wire logic [13:0] pm_addr_i,
  output logic [13:0] pm_rdata_o,
  output logic pm_rvalid_o,
  output logic pm_wr_refused_o,
  // special function register port
  input wire logic sfr_rd_i,
  input wire logic sfr_wr_i,
  input wire logic [8:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // trims to the analog circuits
  output logic [6:0] amp_offset_trim_o,
  output logic [4:0] desat_trim_o,
  output logic [5:0] resistor_trim_o,
  output logic [4:0] reference_trim_o,
  output logic [3:0] thermal_threshold_trim_o,
  output logic [6:0] amp_offset_value_o,
  output logic amp_offset_zero_o,
  output logic [4:0] desat_offset_value_o,
  output logic desat_offset_zero_o
);
  import ftl_pkg::*;

  logic in_region;
  logic [13:0] cal_word;
  logic sel_desat, sel_res, sel_amp, sel_therm, sel_ref;
  logic [7:0] sfr_rd_word;
  logic [6:0] amp_r;
  logic [4:0] desat_r;
  logic [5:0] res_r;
  logic [4:0] ref_r;
  logic [3:0] therm_r;

  // unimplemented bits are masked so they always read zero
  assign cal_word = (pm_addr_i == FTL_AMP_OFFSET_CAL_WORD) ? (CAL_WORD1 & FTL_WORD1_MASK) :
                    (pm_addr_i == FTL_DESAT_AND_RESISTOR_CAL_WORD) ? (CAL_WORD2 & FTL_WORD2_MASK) :
                    (pm_addr_i == FTL_REFERENCE_CAL_WORD) ? (CAL_WORD3 & FTL_WORD3_MASK) :
                    (pm_addr_i == FTL_THERMAL_THRESHOLD_CAL_WORD) ? (CAL_WORD4 & FTL_WORD4_MASK) :
                    14'h0000;
  assign in_region = (pm_addr_i >= FTL_CAL_BASE) && (pm_addr_i <= FTL_CAL_LAST);

  // calibration region answers reads only; writes are dropped
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pm_rdata_o <= 14'h0000;
      pm_rvalid_o <= 1'b0;
      pm_wr_refused_o <= 1'b0;
    end else begin
      pm_rvalid_o <= pm_rd_i && in_region;
      pm_rdata_o <= (pm_rd_i && in_region) ? cal_word : pm_rdata_o;
      pm_wr_refused_o <= pm_wr_i && in_region;
    end
  end

  assign sel_desat = (sfr_addr_i == FTL_DESAT_TRIM_REG);
  assign sel_res = (sfr_addr_i == FTL_RESISTOR_TRIM_REG);
  assign sel_amp = (sfr_addr_i == FTL_AMP_OFFSET_TRIM_REG);
  assign sel_therm = (sfr_addr_i == FTL_THERMAL_THRESHOLD_TRIM_REG);
  assign sel_ref = (sfr_addr_i == FTL_REFERENCE_TRIM_REG);
  assign sfr_rd_word = sel_desat ? {3'h0, desat_r} :
                       sel_res ? {2'h0, res_r} :
                       sel_amp ? {1'h0, amp_r} :
                       sel_therm ? {4'h0, therm_r} :
                       sel_ref ? {3'h0, ref_r} : 8'h00;

  // trim registers written by the loader firmware
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      amp_r <= FTL_TRIM_RESET[6:0];
      desat_r <= FTL_TRIM_RESET[4:0];
      res_r <= FTL_TRIM_RESET[5:0];
      ref_r <= FTL_TRIM_RESET[4:0];
      therm_r <= FTL_TRIM_RESET[3:0];
    end else if (sfr_wr_i) begin
      if (sel_amp) amp_r <= sfr_wdata_i[6:0];
      if (sel_desat) desat_r <= sfr_wdata_i[4:0];
      if (sel_res) res_r <= sfr_wdata_i[5:0];
      if (sel_ref) ref_r <= sfr_wdata_i[4:0];
      if (sel_therm) therm_r <= sfr_wdata_i[3:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= sfr_rd_word;
    end
  end

  assign amp_offset_trim_o = amp_r;
  assign desat_trim_o = desat_r;
  assign resistor_trim_o = res_r;
  assign reference_trim_o = ref_r;
  assign thermal_threshold_trim_o = therm_r;

  // polarity decode of the two offset trims
  ftl_trim_decode #(.W(7), .MID_ALT(FTL_AMP_MID_ALT)) u_amp_dec (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .code_i(amp_r),
    .offset_o(amp_offset_value_o),
    .zero_o(amp_offset_zero_o)
  );
  ftl_trim_decode #(.W(5), .MID_ALT(FTL_DESAT_MID_ALT)) u_desat_dec (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .code_i(desat_r),
    .offset_o(desat_offset_value_o),
    .zero_o(desat_offset_zero_o)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_rd_word1;
    pm_rd_i && pm_addr_i == FTL_AMP_OFFSET_CAL_WORD;
  endsequence

  a_word1_fields: assert property (s_rd_word1 |=> pm_rvalid_o && pm_rdata_o[13:7] == 7'h00
                                   && pm_rdata_o[6:0] == CAL_WORD1[6:0])
    else $error("word 1 read wrong");
  a_word2_fields: assert property (pm_rd_i && pm_addr_i == FTL_DESAT_AND_RESISTOR_CAL_WORD |=>
                                   pm_rdata_o[13] == 1'b0 && pm_rdata_o[12:8] == CAL_WORD2[12:8])
    else $error("word 2 desat field wrong");
  a_word2_res: assert property (pm_rd_i && pm_addr_i == FTL_DESAT_AND_RESISTOR_CAL_WORD |=>
                                pm_rdata_o[7:6] == 2'h0 && pm_rdata_o[5:0] == CAL_WORD2[5:0])
    else $error("word 2 resistor field wrong");
  a_word3_fields: assert property (pm_rd_i && pm_addr_i == FTL_REFERENCE_CAL_WORD |=>
                                   pm_rdata_o == {9'h000, CAL_WORD3[4:0]})
    else $error("word 3 read wrong");
  a_word4_fields: assert property (pm_rd_i && pm_addr_i == FTL_THERMAL_THRESHOLD_CAL_WORD |=>
                                   pm_rdata_o == {10'h000, CAL_WORD4[3:0]})
    else $error("word 4 read wrong");
  a_region_readonly: assert property (pm_wr_i && in_region |=> pm_wr_refused_o
                                      ##0 $stable(pm_rdata_o) || $past(pm_rd_i))
    else $error("write to calibration region not refused");
  a_amp_midscale: assert property (sfr_wr_i && sel_amp && sfr_wdata_i[6:0] == FTL_AMP_MID_ALT |=>
                                   ##1 amp_offset_zero_o && amp_offset_value_o == 7'h00)
    else $error("amp midscale not zero offset");
  a_desat_negmax: assert property (sfr_wr_i && sel_desat && sfr_wdata_i[4:0] == 5'h1F |=>
                                   ##1 desat_offset_value_o == 5'h11 && !desat_offset_zero_o)
    else $error("desat max negative wrong");
  a_trim_copy: assert property (sfr_wr_i && sel_ref |=> reference_trim_o == $past(sfr_wdata_i[4:0]))
    else $error("reference trim not stored");

  // read and write port: pulse on a hit only, read data held between hits
  sequence s_pm_hit;
    pm_rd_i && in_region;
  endsequence
  sequence s_wr_amp;
    sfr_wr_i && sel_amp;
  endsequence
  sequence s_wr_desat;
    sfr_wr_i && sel_desat;
  endsequence

  a_rvalid_hit: assert property (s_pm_hit |=> pm_rvalid_o)
    else $error("calibration read not answered");
  a_rvalid_miss: assert property (pm_rd_i && !in_region |=> !pm_rvalid_o)
    else $error("read outside region answered");
  a_rdata_hold: assert property (!(pm_rd_i && in_region) |=> $stable(pm_rdata_o))
    else $error("read data changed without a hit");
  a_refused_miss: assert property (pm_wr_i && !in_region |=> !pm_wr_refused_o)
    else $error("write outside region flagged");

  // trim registers keep only the field width
  a_amp_store: assert property (s_wr_amp |=> amp_offset_trim_o == $past(sfr_wdata_i[6:0]))
    else $error("amp trim not stored");
  a_desat_store: assert property (s_wr_desat |=> desat_trim_o == $past(sfr_wdata_i[4:0]))
    else $error("desat trim not stored");
  a_res_store: assert property (sfr_wr_i && sel_res |=> resistor_trim_o == $past(sfr_wdata_i[5:0]))
    else $error("resistor trim not stored");
  a_therm_store: assert property (sfr_wr_i && sel_therm |=>
                                  thermal_threshold_trim_o == $past(sfr_wdata_i[3:0]))
    else $error("thermal trim not stored");
  a_ref_upper: assert property (sfr_rd_i && sel_ref |=> sfr_rdata_o[7:5] == 3'h0)
    else $error("reference trim upper bits not zero");
  a_amp_upper: assert property (sfr_rd_i && sel_amp |=> sfr_rdata_o[7] == 1'h0)
    else $error("amp trim upper bit not zero");

  // decoded offsets, two edges after the write
  a_amp_zero_code: assert property (s_wr_amp ##0 sfr_wdata_i[6:0] == 7'h00 |=>
                                    ##1 amp_offset_zero_o && amp_offset_value_o == 7'h00)
    else $error("amp code 00h not zero offset");
  a_amp_polarity: assert property (s_wr_amp ##0 sfr_wdata_i[6] && sfr_wdata_i[5:0] != 6'h00 |=>
                                   ##1 amp_offset_value_o[6] && !amp_offset_zero_o)
    else $error("amp negative code not negative");
  a_desat_mid_alt: assert property (s_wr_desat ##0 sfr_wdata_i[4:0] == FTL_DESAT_MID_ALT |=>
                                    ##1 desat_offset_zero_o && desat_offset_value_o == 5'h00)
    else $error("desat code 10h not zero offset");
  a_desat_posmax: assert property (s_wr_desat ##0 sfr_wdata_i[4:0] == 5'h0F |=>
                                   ##1 desat_offset_value_o == 5'h0F && !desat_offset_zero_o)
    else $error("desat max positive wrong");
endmodule // ftl_loader
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ftl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pm_rd = 1'b0, pm_wr = 1'b0, sfr_rd = 1'b0, sfr_wr = 1'b0;
  logic [13:0] pm_addr = 14'h0000;
  logic [8:0] sfr_addr = 9'h000;
  logic [7:0] sfr_wdata = 8'h00;
  logic [13:0] pm_rdata;
  logic pm_rvalid, pm_ref, amp_z, des_z;
  logic [7:0] sfr_rdata;
  logic [6:0] amp_t, amp_v;
  logic [4:0] des_t, ref_t, des_v;
  logic [5:0] res_t;
  logic [3:0] thr_t;
  int err_total = 0;
  int num_checks = 0;
  logic [13:0] pm_a [4] = '{14'h2080, 14'h2081, 14'h2082, 14'h2083};
  logic [13:0] pm_e [4] = '{14'h0055, 14'h1E2A, 14'h0016, 14'h000B};
  logic [8:0] sf_a [5] = '{9'h199, 9'h196, 9'h197, 9'h19B, 9'h19A};
  logic [7:0] sf_e [5] = '{8'h7F, 8'h1F, 8'h3F, 8'h1F, 8'h0F};

  always #5 ref_clk_i = ~ref_clk_i;

  ftl_loader #(.CAL_WORD1(14'h3FD5), .CAL_WORD2(14'h3EEA), .CAL_WORD3(14'h3FF6), .CAL_WORD4(14'h3FFB)) u_dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .pm_rd_i(pm_rd), .pm_wr_i(pm_wr), .pm_addr_i(pm_addr), .pm_rdata_o(pm_rdata),
    .pm_rvalid_o(pm_rvalid), .pm_wr_refused_o(pm_ref),
    .sfr_rd_i(sfr_rd), .sfr_wr_i(sfr_wr), .sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata),
    .sfr_rdata_o(sfr_rdata), .amp_offset_trim_o(amp_t), .desat_trim_o(des_t),
    .resistor_trim_o(res_t), .reference_trim_o(ref_t), .thermal_threshold_trim_o(thr_t),
    .amp_offset_value_o(amp_v), .amp_offset_zero_o(amp_z),
    .desat_offset_value_o(des_v), .desat_offset_zero_o(des_z));

  task automatic chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one request, taken at the next edge, answer settled on return
  task automatic pm_op(input logic wr, input logic [13:0] a);
    @(posedge ref_clk_i); #1;
    pm_rd = !wr; pm_wr = wr; pm_addr = a;
    @(posedge ref_clk_i); #1;
    pm_rd = 1'b0; pm_wr = 1'b0;
  endtask

  task automatic sfr_op(input logic wr, input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk_i); #1;
    sfr_rd = !wr; sfr_wr = wr; sfr_addr = a; sfr_wdata = d;
    @(posedge ref_clk_i); #1;
    sfr_rd = 1'b0; sfr_wr = 1'b0;
  endtask

  // write a trim code and let the decoded offset settle
  task automatic wdec(input logic [8:0] a, input logic [7:0] d);
    sfr_op(1'b1, a, d);
    @(posedge ref_clk_i); #1;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    chk("trims_rst", 14'h0000, {amp_t, des_t});
    chk("trims_rst_b", 14'h0000, {res_t, ref_t});
    chk("trims_rst_c", 14'h0000, thr_t);
    chk("zero_rst", 14'h0003, {amp_z, des_z});
    for (int i = 0; i < 4; i++) begin
      pm_op(1'b0, pm_a[i]);
      chk("cal_word", pm_e[i], pm_rdata);
      chk("cal_valid", 14'h0001, pm_rvalid);
    end
    pm_op(1'b0, 14'h2084);
    chk("cal_hi", 14'h2000, {pm_rvalid, 13'h0} | pm_rdata);
    @(posedge ref_clk_i); #1;
    chk("rvalid_drop", 14'h0000, pm_rvalid);
    pm_op(1'b0, 14'h207F);
    chk("rvalid_out", 14'h0000, pm_rvalid);
    pm_op(1'b1, 14'h2081);
    chk("wr_refused", 14'h0001, pm_ref);
    @(posedge ref_clk_i); #1;
    chk("refused_drop", 14'h0000, pm_ref);
    pm_op(1'b1, 14'h2090);
    chk("wr_outside", 14'h0000, pm_ref);
    pm_op(1'b0, 14'h2081);
    chk("ro_word", 14'h1E2A, pm_rdata);
    pm_op(1'b0, 14'h2090);
    chk("rdata_hold", 14'h1E2A, pm_rdata);
    for (int i = 0; i < 5; i++) begin
      sfr_op(1'b1, sf_a[i], 8'hFF);
      sfr_op(1'b0, sf_a[i], 8'h00);
      chk("trim_reg", sf_e[i], sfr_rdata);
    end
    chk("trim_outs", 14'h3FFF, {amp_t, des_t, 2'b11} & {7'h7F, 5'h1F, res_t[1:0]});
    chk("trim_outs2", 14'h3FFF, {res_t, ref_t, thr_t[2:0]});
    sfr_op(1'b1, 9'h198, 8'hFF);
    sfr_op(1'b0, 9'h198, 8'h00);
    chk("unmapped", 14'h0000, sfr_rdata);
    wdec(9'h199, 8'h20);
    chk("amp_20", 14'h0001, {amp_v, amp_z});
    wdec(9'h199, 8'h00);
    chk("amp_00", 14'h0001, {amp_v, amp_z});
    wdec(9'h199, 8'h41);
    chk("amp_neg", {7'h7F, 1'b0}, {amp_v, amp_z});
    wdec(9'h196, 8'h1F);
    chk("des_max_neg", {5'h11, 1'b0}, {des_v, des_z});
    wdec(9'h196, 8'h10);
    chk("des_10", 14'h0001, {des_v, des_z});
    wdec(9'h196, 8'h00);
    chk("des_00", 14'h0001, {des_v, des_z});
    wdec(9'h196, 8'h0F);
    chk("des_max_pos", {5'h0F, 1'b0}, {des_v, des_z});
    sys_rst_i = 1'b1;
    @(posedge ref_clk_i); #1;
    sys_rst_i = 1'b0;
    chk("trims_rst2", 14'h0000, {amp_t, des_t});
    chk("trims_rst2_b", 14'h0000, {res_t, ref_t});
    chk("trims_rst2_c", 14'h0000, thr_t);
    chk("zero_rst2", 14'h0003, {amp_z, des_z});
    chk("value_rst2", 14'h0000, {amp_v, des_v});
    close_out();
  end
endmodule // tb
`default_nettype wire
